// File: srs_pkg.sv
// shared constants and carriers for the system reset sequencer
package srs_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int PIN_MIN_PULSE_PS = 1500000;
  localparam int DROP_MIN_LOW_PS  = 2000000;
  // least times round up
  localparam int PIN_MIN_CYC  = (PIN_MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DROP_MIN_CYC = (DROP_MIN_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_W       = 10;
  localparam int DELAY_W      = 21;

  // ==========================================================
  // register map, byte addresses
  localparam int             ADDR_W          = 4;
  localparam logic [3:0]     OFS_CAUSE_FLAGS = 4'h0;
  localparam logic [3:0]     OFS_STATUS      = 4'h4;
  localparam logic [3:0]     OFS_WAKE_MASK   = 4'h8;
  localparam int             PIN_COUNT       = 8;
  localparam logic [7:0]     CAUSE_RESET     = 8'h00;
  localparam logic [7:0]     WAKE_RESET      = 8'h00;
  localparam int             BIT_POWER_ON    = 0;
  localparam int             BIT_PIN         = 1;
  localparam int             BIT_BROWNOUT    = 2;
  localparam int             BIT_WATCHDOG    = 3;
  localparam logic [1:0]     RESP_OKAY       = 2'h0;
  localparam logic [1:0]     RESP_SLVERR     = 2'h2;
  localparam logic [15:0]    RESET_VECTOR    = 16'h0000;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_HOLD    = 4'h2,
    ST_WPULSE  = 4'h4,
    ST_STRETCH = 4'h8
  } srs_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       por_active;
    logic [1:0] below_trip;
    logic [1:0] above_trip;
  } srs_supply_t;

  typedef struct packed {
    logic [3:0] clock_select_fuses;
    logic       supply_drop_enable_fuse;
    logic       supply_drop_level_fuse;
  } srs_fuse_t;

endpackage : srs_pkg

// File: srs_top.sv
// system reset sequencer: sources, stretch counter, cause flags, sleep pin gating
// ==========================================================
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module srs_top #(
  parameter logic [20:0] DELAY_SEL0_CYC = 21'h001000,
  parameter logic [20:0] DELAY_SEL1_CYC = 21'h004000,
  parameter logic [20:0] DELAY_SEL2_CYC = 21'h040000,
  parameter logic [20:0] DELAY_SEL3_CYC = 21'h100000
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [srs_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [srs_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [31:0]                 s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire srs_pkg::srs_supply_t        supply,
  input  wire srs_pkg::srs_fuse_t          fuses,
  input  wire logic                        reset_pin_n,
  input  wire logic                        wdt_enable,
  input  wire logic                        wdt_timeout,
  input  wire logic                        io_clk_stopped,
  output var  logic                        io_reset,
  output var  logic                        core_reset,
  output var  logic                        fetch_start,
  output var  logic [15:0]                 fetch_addr,
  output var  logic                        wdt_run,
  output var  logic                        wdt_reset_pulse,
  output var  logic [srs_pkg::PIN_COUNT-1:0] input_buf_en
);

  // ==========================================================
  // declarations
  srs_pkg::srs_state_t                state_reg;
  srs_pkg::srs_state_t                state_next;
  logic [srs_pkg::FILT_W-1:0]         pin_cnt_reg;
  logic                               pin_rst_reg;
  logic [srs_pkg::FILT_W-1:0]         drop_cnt_reg;
  logic                               drop_rst_reg;
  logic [srs_pkg::DELAY_W-1:0]        delay_reg;
  logic [7:0]                         cause_reg;
  logic [7:0]                         wake_mask_reg;
  logic                               io_reset_reg;
  logic                               core_reset_reg;
  logic                               fetch_start_reg;
  logic                               wdt_pulse_reg;
  logic                               wdt_run_reg;
  logic [srs_pkg::PIN_COUNT-1:0]      buf_en_reg;
  logic                               src_any;
  logic                               wdt_hit;
  logic                               io_async_set;
  logic                               drop_below;
  logic                               drop_above;
  logic                               aw_full_reg;
  logic                               w_full_reg;
  logic [srs_pkg::ADDR_W-1:0]         aw_addr_reg;
  logic [31:0]                        w_data_reg;
  logic [3:0]                         w_strb_reg;
  logic                               bvalid_reg;
  logic [1:0]                         bresp_reg;
  logic                               rvalid_reg;
  logic [31:0]                        rdata_reg;
  logic [1:0]                         rresp_reg;
  logic                               wr_fire;
  logic                               wr_cause;
  logic                               wr_wake;

  // ==========================================================
  // helpers
  function automatic logic [srs_pkg::DELAY_W-1:0] delay_for(input logic [3:0] sel);
    case (sel[1:0])
      2'h0:    delay_for = DELAY_SEL0_CYC;
      2'h1:    delay_for = DELAY_SEL1_CYC;
      2'h2:    delay_for = DELAY_SEL2_CYC;
      default: delay_for = DELAY_SEL3_CYC;
    endcase
  endfunction : delay_for

  function automatic logic reg_hit(input logic [srs_pkg::ADDR_W-1:0] a,
                                   input logic [3:0] ofs);
    reg_hit = (a[srs_pkg::ADDR_W-1:2] == ofs[3:2]);
  endfunction : reg_hit

  // ==========================================================
  // reset sources
  // level fuse picks which comparator pair is watched
  assign drop_below = fuses.supply_drop_level_fuse ? supply.below_trip[1]
                                                   : supply.below_trip[0];
  assign drop_above = fuses.supply_drop_level_fuse ? supply.above_trip[1]
                                                   : supply.above_trip[0];
  assign src_any    = supply.por_active | pin_rst_reg | drop_rst_reg;
  assign wdt_hit    = wdt_enable & wdt_timeout;

  // short pin pulses are filtered out; long ones latch until release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cnt_reg <= '0;
      pin_rst_reg <= 1'b0;
    end else if (reset_pin_n) begin
      pin_cnt_reg <= '0;
      pin_rst_reg <= 1'b0;
    end else if (pin_cnt_reg == srs_pkg::FILT_W'(srs_pkg::PIN_MIN_CYC - 1)) begin
      pin_rst_reg <= 1'b1;
    end else begin
      pin_cnt_reg <= pin_cnt_reg + 1'b1;
    end
  end

  // hysteresis: trip below the lower level, release above the upper
  always_ff @(posedge aclk) begin
    if (!aresetn || !fuses.supply_drop_enable_fuse) begin
      drop_cnt_reg <= '0;
      drop_rst_reg <= 1'b0;
    end else if (drop_rst_reg) begin
      drop_cnt_reg <= '0;
      if (drop_above) begin
        drop_rst_reg <= 1'b0;
      end
    end else if (!drop_below) begin
      drop_cnt_reg <= '0;
    end else if (drop_cnt_reg == srs_pkg::FILT_W'(srs_pkg::DROP_MIN_CYC - 1)) begin
      drop_rst_reg <= 1'b1;
    end else begin
      drop_cnt_reg <= drop_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      srs_pkg::ST_RUN: begin
        if (src_any) begin
          state_next = srs_pkg::ST_HOLD;
        end else if (wdt_hit) begin
          state_next = srs_pkg::ST_WPULSE;
        end
      end
      srs_pkg::ST_HOLD: begin
        if (!src_any) begin
          state_next = srs_pkg::ST_STRETCH;
        end
      end
      srs_pkg::ST_WPULSE: begin
        state_next = src_any ? srs_pkg::ST_HOLD : srs_pkg::ST_STRETCH;
      end
      srs_pkg::ST_STRETCH: begin
        if (src_any) begin
          state_next = srs_pkg::ST_HOLD;
        end else if (delay_reg == '0) begin
          state_next = srs_pkg::ST_RUN;
        end
      end
      default: state_next = srs_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= srs_pkg::ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // reload on entry, so any retrigger starts a full period again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_reg <= '0;
    end else if (state_next == srs_pkg::ST_STRETCH && state_reg != srs_pkg::ST_STRETCH) begin
      delay_reg <= delay_for(fuses.clock_select_fuses) - 1'b1;
    end else if (state_reg == srs_pkg::ST_STRETCH && delay_reg != '0) begin
      delay_reg <= delay_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_reg  <= 1'b1;
      fetch_start_reg <= 1'b0;
      wdt_pulse_reg   <= 1'b0;
    end else begin
      core_reset_reg  <= (state_next != srs_pkg::ST_RUN);
      fetch_start_reg <= (state_reg == srs_pkg::ST_STRETCH) &&
                         (state_next == srs_pkg::ST_RUN);
      wdt_pulse_reg   <= (state_next == srs_pkg::ST_WPULSE);
    end
  end

  // i/o reset sets without a clock edge; glitches on the raw sources
  // can reset the ports early, which is the safe direction
  assign io_async_set = supply.por_active | ~reset_pin_n | drop_rst_reg;

  always_ff @(posedge aclk or posedge io_async_set) begin
    if (io_async_set) begin
      io_reset_reg <= 1'b1;
    end else if (!aresetn) begin
      io_reset_reg <= 1'b1;
    end else begin
      io_reset_reg <= (state_next != srs_pkg::ST_RUN);
    end
  end

  // ==========================================================
  // sleep behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_run_reg <= 1'b0;
      buf_en_reg  <= '1;
    end else begin
      wdt_run_reg <= wdt_enable;
      buf_en_reg  <= io_clk_stopped ? wake_mask_reg : {srs_pkg::PIN_COUNT{1'b1}};
    end
  end

  // ==========================================================
  // cause flags
  assign wr_fire  = bvalid_reg == 1'b0 && aw_full_reg && w_full_reg;
  assign wr_cause = wr_fire && reg_hit(aw_addr_reg, srs_pkg::OFS_CAUSE_FLAGS) && w_strb_reg[0];
  assign wr_wake  = wr_fire && reg_hit(aw_addr_reg, srs_pkg::OFS_WAKE_MASK) && w_strb_reg[0];

  // a cause present in the cycle of a clearing write survives it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg <= srs_pkg::CAUSE_RESET;
    end else begin
      if (supply.por_active) begin
        cause_reg[srs_pkg::BIT_WATCHDOG] <= 1'b0;
        cause_reg[srs_pkg::BIT_BROWNOUT] <= 1'b0;
        cause_reg[srs_pkg::BIT_PIN]      <= 1'b0;
      end else begin
        cause_reg[srs_pkg::BIT_WATCHDOG] <= (state_reg == srs_pkg::ST_WPULSE) |
          (cause_reg[srs_pkg::BIT_WATCHDOG] &
           ~(wr_cause & ~w_data_reg[srs_pkg::BIT_WATCHDOG]));
        cause_reg[srs_pkg::BIT_BROWNOUT] <= drop_rst_reg |
          (cause_reg[srs_pkg::BIT_BROWNOUT] &
           ~(wr_cause & ~w_data_reg[srs_pkg::BIT_BROWNOUT]));
        cause_reg[srs_pkg::BIT_PIN] <= pin_rst_reg |
          (cause_reg[srs_pkg::BIT_PIN] &
           ~(wr_cause & ~w_data_reg[srs_pkg::BIT_PIN]));
      end
      cause_reg[srs_pkg::BIT_POWER_ON] <= supply.por_active |
        (cause_reg[srs_pkg::BIT_POWER_ON] &
         ~(wr_cause & ~w_data_reg[srs_pkg::BIT_POWER_ON]));
      cause_reg[7:4] <= 4'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_mask_reg <= srs_pkg::WAKE_RESET;
    end else if (wr_wake) begin
      wake_mask_reg <= w_data_reg[7:0];
    end
  end

  // ==========================================================
  // axi4-lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= srs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (reg_hit(aw_addr_reg, srs_pkg::OFS_CAUSE_FLAGS) ||
                     reg_hit(aw_addr_reg, srs_pkg::OFS_STATUS) ||
                     reg_hit(aw_addr_reg, srs_pkg::OFS_WAKE_MASK))
                    ? srs_pkg::RESP_OKAY : srs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= srs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= srs_pkg::RESP_OKAY;
      if (reg_hit(s_axi_araddr, srs_pkg::OFS_CAUSE_FLAGS)) begin
        rdata_reg <= {24'h000000, cause_reg};
      end else if (reg_hit(s_axi_araddr, srs_pkg::OFS_STATUS)) begin
        rdata_reg <= {22'h000000, pin_rst_reg, drop_rst_reg, supply.por_active,
                      delay_reg != '0, core_reset_reg, io_reset_reg, state_reg};
      end else if (reg_hit(s_axi_araddr, srs_pkg::OFS_WAKE_MASK)) begin
        rdata_reg <= {24'h000000, wake_mask_reg};
      end else begin
        rdata_reg <= '0;
        rresp_reg <= srs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready   = ~aw_full_reg;
  assign s_axi_wready    = ~w_full_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_arready   = ~rvalid_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign s_axi_rdata     = rdata_reg;
  assign s_axi_rresp     = rresp_reg;
  assign io_reset        = io_reset_reg;
  assign core_reset      = core_reset_reg;
  assign fetch_start     = fetch_start_reg;
  assign fetch_addr      = srs_pkg::RESET_VECTOR;
  assign wdt_run         = wdt_run_reg;
  assign wdt_reset_pulse = wdt_pulse_reg;
  assign input_buf_en    = buf_en_reg;

endmodule : srs_top

`default_nettype wire

// File: srs_top_checker.sv
// port assertions for the system reset sequencer
`timescale 1ns/1ps
`default_nettype none

module srs_top_checker (
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          reset_pin_n,
  input wire srs_pkg::srs_supply_t          supply,
  input wire logic                          wdt_enable,
  input wire logic                          wdt_timeout,
  input wire logic                          io_clk_stopped,
  input wire logic                          io_reset,
  input wire logic                          core_reset,
  input wire logic                          fetch_start,
  input wire logic [15:0]                   fetch_addr,
  input wire logic                          wdt_run,
  input wire logic                          wdt_reset_pulse,
  input wire logic [srs_pkg::PIN_COUNT-1:0] input_buf_en
);
  // ==========================================================
  // clocking
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // sequences
  sequence s_pin_up;
    $rose(reset_pin_n) && core_reset;
  endsequence
  sequence s_released;
    !core_reset && $past(core_reset);
  endsequence

  // ==========================================================
  // assertions
  a_fetch_vector: assert property (fetch_start |->
    s_released ##0 fetch_addr == srs_pkg::RESET_VECTOR)
    else $error("fetch start not at reset release");
  a_io_async_set: assert property ((supply.por_active || !reset_pin_n) |-> io_reset)
    else $error("io reset low while a source is active");
  a_pin_stretch: assert property (s_pin_up |-> core_reset [*8])
    else $error("reset released too soon after pin");
  a_wdt_cause: assert property (wdt_reset_pulse |->
    core_reset && $past(wdt_enable) && $past(wdt_timeout))
    else $error("watchdog pulse without enabled expiry");
  a_wdt_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("watchdog pulse longer than one cycle");
  a_por_hold: assert property (supply.por_active |=> core_reset)
    else $error("core reset low during power-on");
  a_wdt_sleep_run: assert property ($past(aresetn) |-> wdt_run == $past(wdt_enable))
    else $error("watchdog run not following enable");
  a_buf_awake: assert property (!$past(io_clk_stopped) |-> input_buf_en == 8'hFF)
    else $error("input buffers gated while io clock runs");

endmodule : srs_top_checker
`default_nettype wire

// File: srs_supply_model.sv
// supply monitors and reset pin driver at the far side
`timescale 1ns/1ps
`default_nettype none

module srs_supply_model (
  input  wire logic                 pin_low_req,
  input  wire logic                 por_req,
  input  wire logic [1:0]           drop_req,
  output var  logic                 reset_pin_n,
  output var  srs_pkg::srs_supply_t supply
);
  // ==========================================================
  // levels, combinational so a source shows without any clock
  always_comb begin
    reset_pin_n       = ~pin_low_req;
    supply.por_active = por_req;
    supply.below_trip = drop_req;
    // comparators are exclusive, no level both above and below
    supply.above_trip = ~drop_req;
  end

endmodule : srs_supply_model
`default_nettype wire

// File: system_reset_sequencer_test.sv
// self-checking bench for the system reset sequencer
`timescale 1ns/1ps
`default_nettype none

module system_reset_sequencer_test;
  localparam int N = 16;
  logic                 aclk, aresetn;
  logic [3:0]           awaddr, araddr, wstrb;
  logic                 awvalid, wvalid, arvalid, bready, rready;
  logic [31:0]          wdata, rdata, d;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [1:0]           bresp, rresp, r, drop_req;
  srs_pkg::srs_supply_t supply;
  srs_pkg::srs_fuse_t   fuses;
  logic                 reset_pin_n, pin_low_req, por_req;
  logic                 wdt_enable, wdt_timeout, io_clk_stopped;
  logic                 io_reset, core_reset, fetch_start, wdt_run, wdt_reset_pulse;
  logic [15:0]          fetch_addr;
  logic [7:0]           input_buf_en;
  int                   fails, samples_checked, n;

  srs_supply_model u_srs_supply_model (.pin_low_req(pin_low_req), .por_req(por_req),
    .drop_req(drop_req), .reset_pin_n(reset_pin_n), .supply(supply));

  srs_top #(.DELAY_SEL0_CYC(21'h000010)) u_srs_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply(supply), .fuses(fuses), .reset_pin_n(reset_pin_n), .wdt_enable(wdt_enable),
    .wdt_timeout(wdt_timeout), .io_clk_stopped(io_clk_stopped), .io_reset(io_reset),
    .core_reset(core_reset), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .wdt_run(wdt_run), .wdt_reset_pulse(wdt_reset_pulse), .input_buf_en(input_buf_en));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // bready and rready stay high, so every answer is taken at once
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    int t;
    t = 0;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && t < 200);
    if (t >= 200) fails++;
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    int t;
    t = 0;
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && t < 200);
    if (t >= 200) fails++;
    d = rdata; r = rresp;
  endtask : axi_rd

  task automatic wait_free();
    n = 0;
    while (core_reset !== 1'b0 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) fails++;
  endtask : wait_free

  // ==========================================================
  // scenarios
  task automatic t_por();
    por_req <= 1'b1; cyc(5);
    chk(core_reset, 1);
    por_req <= 1'b0; wait_free();
    chk(n >= N, 1);
    chk(fetch_start, 1);
    chk(fetch_addr, 32'h0);
    axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h01);
    $display("t_por done");
  endtask : t_por

  task automatic t_pin();
    pin_low_req <= 1'b1; @(posedge aclk); #1;
    chk(io_reset, 1);
    @(posedge aclk); cyc(98);
    pin_low_req <= 1'b0; cyc(3);
    chk(core_reset, 0);
    pin_low_req <= 1'b1; cyc(400);
    pin_low_req <= 1'b0; cyc(5);
    // a second long pulse begun in mid-stretch trips only after the 16-cycle stretch has ended, then starts the count again
    pin_low_req <= 1'b1; cyc(400);
    pin_low_req <= 1'b0; wait_free();
    chk(n >= N, 1);
    axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h03);
    axi_wr(srs_pkg::OFS_CAUSE_FLAGS, 32'hFE); axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h02);
    axi_wr(srs_pkg::OFS_CAUSE_FLAGS, 32'h0); axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h0);
    $display("t_pin done");
  endtask : t_pin

  task automatic t_wdt();
    wdt_enable <= 1'b0; wdt_timeout <= 1'b1; cyc(1);
    wdt_timeout <= 1'b0; cyc(3);
    chk(core_reset, 0);
    wdt_enable <= 1'b1; wdt_timeout <= 1'b1; cyc(1);
    wdt_timeout <= 1'b0; cyc(1);
    chk(wdt_reset_pulse, 1);
    cyc(1);
    chk(wdt_reset_pulse, 0);
    chk(core_reset, 1);
    wait_free();
    chk(n >= N - 2, 1);
    axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h08);
    axi_wr(srs_pkg::OFS_CAUSE_FLAGS, 32'h0); axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h0);
    $display("t_wdt done");
  endtask : t_wdt

  task automatic t_bod();
    fuses.supply_drop_enable_fuse <= 1'b0; drop_req <= 2'b11; cyc(600);
    chk(core_reset, 0);
    fuses.supply_drop_enable_fuse <= 1'b1; drop_req <= 2'b10; cyc(600);
    chk(core_reset, 0);
    drop_req <= 2'b11; cyc(100);
    drop_req <= 2'b00; cyc(3);
    chk(core_reset, 0);
    drop_req <= 2'b11; cyc(600);
    chk(core_reset, 1);
    chk(io_reset, 1);
    drop_req <= 2'b00; wait_free();
    chk(n >= N, 1);
    axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h04);
    fuses.supply_drop_level_fuse <= 1'b1; drop_req <= 2'b10; cyc(600);
    chk(core_reset, 1);
    drop_req <= 2'b00; wait_free();
    axi_wr(srs_pkg::OFS_CAUSE_FLAGS, 32'h0); axi_rd(srs_pkg::OFS_CAUSE_FLAGS);
    chk(d, 32'h0);
    $display("t_bod done");
  endtask : t_bod

  task automatic t_regs();
    // running, idle sources: state run, no reset, no count pending
    axi_rd(srs_pkg::OFS_STATUS);
    chk(d, 32'h001);
    axi_rd(4'hC);
    chk(r, srs_pkg::RESP_SLVERR);
    axi_wr(4'hC, 32'h0);
    chk(r, srs_pkg::RESP_SLVERR);
    axi_wr(srs_pkg::OFS_WAKE_MASK, 32'h5A);
    chk(r, srs_pkg::RESP_OKAY);
    axi_rd(srs_pkg::OFS_WAKE_MASK);
    chk(d, 32'h5A);
    io_clk_stopped <= 1'b1; cyc(3);
    chk(input_buf_en, 8'h5A);
    chk(wdt_run, 1);
    io_clk_stopped <= 1'b0; cyc(3);
    chk(input_buf_en, 8'hFF);
    $display("t_regs done");
  endtask : t_regs

  // ==========================================================
  // run control
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    #(4 * 60000);
    fails++;
    finish_test();
  end

  initial begin
    fails = 0; samples_checked = 0; aresetn = 1'b0;
    awaddr = 4'h0; araddr = 4'h0; wstrb = 4'hF; wdata = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; bready = 1'b1; rready = 1'b1;
    pin_low_req = 1'b0; por_req = 1'b0; drop_req = 2'b00;
    fuses = '0; wdt_enable = 1'b0; wdt_timeout = 1'b0; io_clk_stopped = 1'b0;
    cyc(12);
    aresetn <= 1'b1;
    wait_free();
    t_por(); t_pin(); t_wdt(); t_bod(); t_regs();
    finish_test();
  end

endmodule : system_reset_sequencer_test

bind srs_top srs_top_checker u_srs_top_checker (.aclk(aclk), .aresetn(aresetn),
  .reset_pin_n(reset_pin_n), .supply(supply), .wdt_enable(wdt_enable),
  .wdt_timeout(wdt_timeout), .io_clk_stopped(io_clk_stopped), .io_reset(io_reset),
  .core_reset(core_reset), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
  .wdt_run(wdt_run), .wdt_reset_pulse(wdt_reset_pulse), .input_buf_en(input_buf_en));
`default_nettype wire
